// *** hdl/pbc_regs.svh ***
// register offsets, field positions, reset values and counts for the phy control bank
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

`define PBC_OFS_CTRL        16'h0140
`define PBC_OFS_STAT        16'h0142
`define PBC_OFS_ADV         16'h0144
`define PBC_OFS_IRQ_STAT    16'h0150
`define PBC_OFS_IRQ_MASK    16'h0152

`define PBC_CTRL_RST        15
`define PBC_CTRL_SPD        13
`define PBC_CTRL_ANE        12
`define PBC_CTRL_RESTART    9
`define PBC_CTRL_DPX        8

`define PBC_STAT_ANC        5
`define PBC_STAT_RFLT       4
`define PBC_STAT_FIXED      16'h7809

`define PBC_ADV_ACK         14
`define PBC_ADV_RF          13
`define PBC_ADV_PAUSE       10
`define PBC_ADV_RESET       16'h01E1
`define PBC_ADV_WR_MASK     16'h21E0

`define PBC_IRQ_ANC         0
`define PBC_IRQ_RFLT        1
`define PBC_IRQ_ACK         2
`define PBC_IRQ_W           3

`define PBC_WARM_CYCLES     2'h3

`endif

// *** hdl/pbc_pkg.sv ***
// types shared by the phy control bank modules
package pbc_pkg;

	typedef enum logic [1:0] {
		PBC_AN_IDLE = 2'h0,
		PBC_AN_RUN  = 2'h1,
		PBC_AN_DONE = 2'h3
	} pbc_an_state_t;

	typedef logic [15:0] pbc_word_t;

endpackage

// *** hdl/pbc_an_if.sv ***
// carrier between the register bank and the negotiation sequencer
interface pbc_an_if;
	logic soft_rst;
	logic enable;
	logic restart_req;
	logic restart_taken;
	logic engine_restart;
	logic engine_done;
	logic res_speed_100;
	logic res_full_duplex;
	logic complete;
	logic speed_100;
	logic full_duplex;

	modport ctl (
		input  soft_rst, enable, restart_req, engine_done, res_speed_100, res_full_duplex,
		output restart_taken, engine_restart, complete, speed_100, full_duplex
	);
	modport bank (
		output soft_rst, enable, restart_req, engine_done, res_speed_100, res_full_duplex,
		input  restart_taken, engine_restart, complete, speed_100, full_duplex
	);
endinterface

// *** hdl/pbc_sync.sv ***
// three-stage synchroniser, output follows once the last two stages agree
module pbc_sync #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset,
	// data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic s1_reg;
		logic s2_reg;
		logic s3_reg;
		always_ff @(posedge sys_clk) begin
			if (reset) begin
				s1_reg      <= 1'b0;
				s2_reg      <= 1'b0;
				s3_reg      <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				s1_reg <= async_in[i];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				if (s2_reg == s3_reg) begin
					sync_out[i] <= s3_reg;
				end
			end
		end
	end
endmodule

// *** hdl/pbc_anctl.sv ***
// auto-negotiation sequencer: starts the engine and holds its result
module pbc_anctl (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// bank side
	pbc_an_if.ctl     an
);
	import pbc_pkg::*;

	pbc_an_state_t state_reg;
	logic          start;

	// a taken request is still visible for one cycle, so it must not start twice
	assign start = an.enable && ((state_reg == PBC_AN_IDLE) || (an.restart_req && !an.restart_taken));

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset || an.soft_rst) begin
			state_reg <= PBC_AN_IDLE;
		end else if (!an.enable) begin
			state_reg <= PBC_AN_IDLE;
		end else begin
			case (state_reg)
				PBC_AN_IDLE: state_reg <= PBC_AN_RUN;
				PBC_AN_RUN: begin
					if (an.restart_req) begin
						state_reg <= PBC_AN_RUN;
					end else if (an.engine_done) begin
						state_reg <= PBC_AN_DONE;
					end
				end
				PBC_AN_DONE: begin
					if (an.restart_req) begin
						state_reg <= PBC_AN_RUN; // RULE5
					end
				end
				default: state_reg <= PBC_AN_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// restart strobes and completion
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset || an.soft_rst) begin
			an.engine_restart <= 1'b0;
			an.restart_taken  <= 1'b0;
			an.complete       <= 1'b0;
		end else begin
			an.engine_restart <= start; // RULE5
			an.restart_taken  <= start && an.restart_req; // RULE17
			if (start || !an.enable) begin
				an.complete <= 1'b0;
			end else if (state_reg == PBC_AN_RUN && an.engine_done) begin
				an.complete <= 1'b1; // RULE7
			end
		end
	end

	// ----------------------------------------
	// negotiated result
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset || an.soft_rst) begin
			an.speed_100   <= 1'b0;
			an.full_duplex <= 1'b0;
		end else if (state_reg == PBC_AN_RUN && an.engine_done && !an.restart_req) begin
			an.speed_100   <= an.res_speed_100; // RULE3
			an.full_duplex <= an.res_full_duplex;
		end
	end
endmodule

// *** hdl/pbc_top.sv ***
// phy basic control, status and advertisement register bank
// Summary of operation
// RULE1: writing one to control bit 15 restores defaults; the bit clears itself
// RULE2: control bit 13 selects 100 or 10 Mb/s; bit 8 full or half duplex
// RULE3: with negotiation enabled, written speed/duplex ignored; bits show negotiated result
// RULE4: speed, negotiation enable and duplex power up from configuration straps
// RULE5: writing one to control bit 9 restarts negotiation
// RULE6: status bit 15 reads zero; bits 14 to 11 read one
// RULE7: status bit 5 reads one once negotiation completed, resets to zero
// RULE8: status bit 4 set on remote fault, cleared by a status read
// RULE9: status bits 3 and 0 read one, read-only
// RULE10: advertisement bit 15 reads zero, read-only
// RULE11: advertisement bit 14 reads one once partner word acknowledged, resets zero
// RULE12: advertisement bit 13 writable, resets zero, advertises remote fault ability
// RULE13: advertisement bit 10 read-only, taken from configuration straps
// RULE14: advertisement bit 9 reads zero, read-only
// RULE15: advertisement bits 8 to 5 writable, reset to one
// RULE16: selector field resets to the csma/cd code, no other value accepted
// RULE17: restart bit clears once negotiation restarted; reserved bits read zero
`include "pbc_regs.svh"

module pbc_top (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset,
	// register port
	input  wire logic [15:0]       reg_addr,
	input  wire pbc_pkg::pbc_word_t reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output pbc_pkg::pbc_word_t     reg_rdata,
	// configuration strap pins
	input  wire logic              cfg_speed_100,
	input  wire logic              cfg_autoneg,
	input  wire logic              cfg_full_duplex,
	input  wire logic              cfg_pause,
	// negotiation engine
	input  wire logic              an_engine_done,
	input  wire logic              an_result_speed_100,
	input  wire logic              an_result_full_duplex,
	input  wire logic              an_partner_ack,
	input  wire logic              remote_fault_det,
	output logic                   an_engine_restart,
	output logic                   an_enable_out,
	output logic                   link_speed_100,
	output logic                   link_full_duplex,
	output pbc_pkg::pbc_word_t     adv_word,
	// interrupt
	output logic                   irq
);
	import pbc_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	pbc_an_if an ();

	logic [3:0]                cfg_sync;
	logic [1:0]                warm_reg;
	logic                      straps_loaded_reg;
	logic                      strap_arm_reg;
	logic                      load_defaults;
	logic                      soft_rst_reg;
	logic                      spd_reg;
	logic                      ane_reg;
	logic                      dpx_reg;
	logic                      restart_reg;
	logic                      pause_reg;
	logic                      rflt_reg;
	logic                      ack_reg;
	logic                      adv_rf_reg;
	logic [3:0]                adv_abil_reg;
	logic [`PBC_IRQ_W-1:0]     irq_stat_reg;
	logic [`PBC_IRQ_W-1:0]     irq_mask_reg;
	logic [`PBC_IRQ_W-1:0]     irq_event;
	logic                      complete_prev_reg;
	logic                      eff_speed;
	logic                      eff_duplex;
	logic                      wr_ctrl;
	logic                      wr_adv;
	logic                      wr_istat;
	logic                      wr_imask;
	logic                      rd_stat;
	pbc_word_t                 ctrl_view;
	pbc_word_t                 stat_view;
	pbc_word_t                 adv_view;

	// ----------------------------------------
	// strap synchroniser and sequencer
	// ----------------------------------------
	pbc_sync #(
		.W (4)
	) u_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({cfg_pause, cfg_full_duplex, cfg_autoneg, cfg_speed_100}),
		.sync_out (cfg_sync)
	);

	pbc_anctl u_anctl (
		.sys_clk (sys_clk),
		.reset   (reset),
		.an      (an)
	);

	assign an.soft_rst        = soft_rst_reg;
	assign an.enable          = ane_reg;
	assign an.restart_req     = restart_reg;
	assign an.engine_done     = an_engine_done;
	assign an.res_speed_100   = an_result_speed_100;
	assign an.res_full_duplex = an_result_full_duplex;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign wr_ctrl  = reg_wr && (reg_addr == `PBC_OFS_CTRL);
	assign wr_adv   = reg_wr && (reg_addr == `PBC_OFS_ADV);
	assign wr_istat = reg_wr && (reg_addr == `PBC_OFS_IRQ_STAT);
	assign wr_imask = reg_wr && (reg_addr == `PBC_OFS_IRQ_MASK);
	assign rd_stat  = reg_rd && (reg_addr == `PBC_OFS_STAT);

	// ----------------------------------------
	// strap capture after reset release
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			warm_reg <= 2'h0;
		end else if (warm_reg != `PBC_WARM_CYCLES) begin
			warm_reg <= warm_reg + 2'h1;
		end
	end

	// synchroniser output settles one edge after the counter saturates
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			strap_arm_reg <= 1'b0;
		end else begin
			strap_arm_reg <= (warm_reg == `PBC_WARM_CYCLES);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			straps_loaded_reg <= 1'b0;
		end else if (strap_arm_reg) begin
			straps_loaded_reg <= 1'b1;
		end
	end

	assign load_defaults = (strap_arm_reg && !straps_loaded_reg) || soft_rst_reg;

	// ----------------------------------------
	// software reset pulse
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= wr_ctrl && reg_wdata[`PBC_CTRL_RST]; // RULE1
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			spd_reg <= 1'b0;
			ane_reg <= 1'b0;
			dpx_reg <= 1'b0;
		end else if (load_defaults) begin
			spd_reg <= cfg_sync[0]; // RULE4
			ane_reg <= cfg_sync[1]; // RULE1
			dpx_reg <= cfg_sync[2];
		end else if (wr_ctrl && !reg_wdata[`PBC_CTRL_RST]) begin
			spd_reg <= reg_wdata[`PBC_CTRL_SPD]; // RULE2
			ane_reg <= reg_wdata[`PBC_CTRL_ANE];
			dpx_reg <= reg_wdata[`PBC_CTRL_DPX];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			restart_reg <= 1'b0;
		end else if (soft_rst_reg || an.restart_taken || !ane_reg) begin
			restart_reg <= 1'b0; // RULE17
		end else if (wr_ctrl && reg_wdata[`PBC_CTRL_RESTART] && !reg_wdata[`PBC_CTRL_RST]) begin
			restart_reg <= 1'b1; // RULE5
		end
	end

	assign eff_speed  = ane_reg ? an.speed_100 : spd_reg; // RULE3
	assign eff_duplex = ane_reg ? an.full_duplex : dpx_reg;

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset || soft_rst_reg) begin
			rflt_reg <= 1'b0;
		end else if (remote_fault_det) begin
			rflt_reg <= 1'b1; // RULE8
		end else if (rd_stat) begin
			rflt_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// advertisement register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			adv_rf_reg   <= 1'b0;
			adv_abil_reg <= 4'hF;
			pause_reg    <= 1'b0;
		end else if (load_defaults) begin
			adv_rf_reg   <= 1'b0; // RULE12
			adv_abil_reg <= 4'(`PBC_ADV_RESET >> 5); // RULE15
			pause_reg    <= cfg_sync[3]; // RULE13
		end else if (wr_adv) begin
			adv_rf_reg   <= reg_wdata[`PBC_ADV_RF]; // RULE12
			adv_abil_reg <= reg_wdata[8:5]; // RULE15
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || soft_rst_reg || an.engine_restart || !ane_reg) begin
			ack_reg <= 1'b0;
		end else if (an_partner_ack) begin
			ack_reg <= 1'b1; // RULE11
		end
	end

	// ----------------------------------------
	// read views
	// ----------------------------------------
	always_comb begin
		ctrl_view                    = 16'h0000; // RULE17
		ctrl_view[`PBC_CTRL_SPD]     = eff_speed; // RULE3
		ctrl_view[`PBC_CTRL_ANE]     = ane_reg;
		ctrl_view[`PBC_CTRL_RESTART] = restart_reg;
		ctrl_view[`PBC_CTRL_DPX]     = eff_duplex;
	end

	always_comb begin
		stat_view                 = `PBC_STAT_FIXED; // RULE6 RULE9
		stat_view[`PBC_STAT_ANC]  = an.complete; // RULE7
		stat_view[`PBC_STAT_RFLT] = rflt_reg; // RULE8
	end

	always_comb begin
		adv_view                 = `PBC_ADV_WR_MASK & `PBC_ADV_RESET; // RULE16 RULE10 RULE14
		adv_view[`PBC_ADV_ACK]   = ack_reg; // RULE11
		adv_view[`PBC_ADV_RF]    = adv_rf_reg;
		adv_view[`PBC_ADV_PAUSE] = pause_reg; // RULE13
		adv_view[8:5]            = adv_abil_reg;
		adv_view[4:0]            = 5'(`PBC_ADV_RESET & 16'h001F); // RULE16
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`PBC_OFS_CTRL:     reg_rdata <= ctrl_view;
				`PBC_OFS_STAT:     reg_rdata <= stat_view;
				`PBC_OFS_ADV:      reg_rdata <= adv_view;
				`PBC_OFS_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_reg};
				`PBC_OFS_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_reg};
				default:           reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			complete_prev_reg <= 1'b0;
		end else begin
			complete_prev_reg <= an.complete;
		end
	end

	assign irq_event[`PBC_IRQ_ANC]  = an.complete && !complete_prev_reg;
	assign irq_event[`PBC_IRQ_RFLT] = remote_fault_det;
	assign irq_event[`PBC_IRQ_ACK]  = an_partner_ack && !ack_reg && ane_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_stat_reg <= '0;
		end else if (wr_istat) begin
			irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`PBC_IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_event;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_mask_reg <= '0;
		end else if (wr_imask) begin
			irq_mask_reg <= reg_wdata[`PBC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ----------------------------------------
	// outputs to the link side
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			an_engine_restart <= 1'b0;
			an_enable_out     <= 1'b0;
			link_speed_100    <= 1'b0;
			link_full_duplex  <= 1'b0;
			adv_word          <= 16'h0000;
		end else begin
			an_engine_restart <= an.engine_restart; // RULE5
			an_enable_out     <= ane_reg;
			link_speed_100    <= eff_speed; // RULE2
			link_full_duplex  <= eff_duplex;
			adv_word          <= adv_view;
		end
	end
endmodule

// *** sim/pbc_partner.sv ***
// negotiation engine stand-in that answers restart pulses
module pbc_partner (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// bank side
	input  wire logic       an_engine_restart,
	input  wire logic       an_enable_out,
	output logic            an_engine_done,
	output logic            an_result_speed_100,
	output logic            an_result_full_duplex,
	output logic            an_partner_ack,
	// bench control
	input  wire logic [5:0] delay,
	input  wire logic [1:0] result
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// ack one cycle before done, results only meaningful with done
	always_ff @(posedge sys_clk) begin
		an_engine_done <= 1'b0;
		an_partner_ack <= 1'b0;
		if (reset || !an_enable_out) begin
			cnt <= 0;
		end else if (an_engine_restart) begin
			cnt <= int'(delay) + 2;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			an_partner_ack <= (cnt == 2);
			an_engine_done <= (cnt == 1);
		end
		{an_result_speed_100, an_result_full_duplex} <= (cnt == 1) ? result
			: ~{an_result_speed_100, an_result_full_duplex};
	end
endmodule

// *** sim/pbc_chk.sv ***
// port checks for the phy control bank
`include "pbc_regs.svh"
module pbc_chk (
	// clock and reset
	input wire logic               sys_clk,
	input wire logic               reset,
	// register port
	input wire logic [15:0]        reg_addr,
	input wire logic               reg_rd,
	input wire pbc_pkg::pbc_word_t reg_rdata,
	// negotiation engine
	input wire logic               an_engine_done,
	input wire logic               an_result_speed_100,
	input wire logic               an_result_full_duplex,
	input wire logic               remote_fault_det,
	input wire logic               an_engine_restart,
	input wire logic               an_enable_out,
	input wire logic               link_speed_100,
	input wire logic               link_full_duplex,
	input wire pbc_pkg::pbc_word_t adv_word
);
	timeunit 1ns;
	timeprecision 1ns;
	import pbc_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	a_ctrl_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == `PBC_OFS_CTRL |->
		(reg_rdata & 16'hCCFF) == 16'h0000) else $error("control reserved bits set");
	a_stat_fixed: assert property ($past(reg_rd) && $past(reg_addr) == `PBC_OFS_STAT |->
		(reg_rdata & 16'hFFCF) == `PBC_STAT_FIXED) else $error("status fixed bits wrong");
	a_adv_fixed: assert property ($past(reg_rd) && $past(reg_addr) == `PBC_OFS_ADV |->
		(reg_rdata & 16'h9A1F) == 16'h0001) else $error("advert fixed bits wrong");
	a_adv_word_fixed: assert property (!$past(reset) && !$past(reset, 2) |->
		(adv_word & 16'h9A1F) == 16'h0001) else $error("advert word fixed bits wrong");
	a_restart_pulse: assert property (an_engine_restart |=> !an_engine_restart)
		else $error("restart pulse too long");
	a_restart_enabled: assert property (an_engine_restart |-> an_enable_out)
		else $error("restart without enable");
	a_rflt_set: assert property (remote_fault_det ##1 !reg_rd ##1 reg_rd && reg_addr == `PBC_OFS_STAT
		|=> reg_rdata[4]) else $error("remote fault not reported");
	a_rflt_clear: assert property (reg_rd && reg_addr == `PBC_OFS_STAT && !remote_fault_det ##1
		!remote_fault_det ##1 reg_rd && reg_addr == `PBC_OFS_STAT |=> !reg_rdata[4])
		else $error("remote fault not cleared by read");
	a_anc_read: assert property (an_enable_out && an_engine_done ##2 reg_rd && reg_addr == `PBC_OFS_STAT
		|=> reg_rdata[5]) else $error("completion not reported");
	a_link_result: assert property (an_enable_out && an_engine_done ##3 an_enable_out |->
		{link_speed_100, link_full_duplex} == $past({an_result_speed_100, an_result_full_duplex}, 3))
		else $error("link mode differs from result");

	c_restart: cover property (an_engine_restart);
	c_done: cover property (an_enable_out && an_engine_done);
	c_rflt: cover property ($past(reg_rd) && reg_rdata[4]);
endmodule

bind pbc_top pbc_chk chk_u (
	.sys_clk(sys_clk),
	.reset(reset),
	.reg_addr(reg_addr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.an_engine_done(an_engine_done),
	.an_result_speed_100(an_result_speed_100),
	.an_result_full_duplex(an_result_full_duplex),
	.remote_fault_det(remote_fault_det),
	.an_engine_restart(an_engine_restart),
	.an_enable_out(an_enable_out),
	.link_speed_100(link_speed_100),
	.link_full_duplex(link_full_duplex),
	.adv_word(adv_word)
);

// *** sim/tb_phy_basic_control_status_regs.sv ***
// self-checking bench for the phy control bank
`include "pbc_regs.svh"
module tb_phy_basic_control_status_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import pbc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        rflt = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	pbc_word_t   reg_wdata = 16'h0000;
	pbc_word_t   reg_rdata;
	pbc_word_t   d;
	pbc_word_t   adv_o;
	logic [3:0]  cfg = 4'h0;
	logic [5:0]  dly = 6'h28;
	logic [1:0]  res = 2'h0;
	logic        eng_rst, ane_o, spd_o, fdx_o, done, rs, rf, ack, irq;
	int          err_count = 0;
	int          comparisons = 0;

	always #25 sys_clk = ~sys_clk;

	pbc_top dut_u (
		.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cfg_speed_100(cfg[3]), .cfg_autoneg(cfg[2]), .cfg_full_duplex(cfg[1]), .cfg_pause(cfg[0]),
		.an_engine_done(done), .an_result_speed_100(rs), .an_result_full_duplex(rf),
		.an_partner_ack(ack), .remote_fault_det(rflt), .an_engine_restart(eng_rst),
		.an_enable_out(ane_o), .link_speed_100(spd_o), .link_full_duplex(fdx_o),
		.adv_word(adv_o), .irq(irq)
	);
	pbc_partner eng_u (
		.sys_clk(sys_clk), .reset(reset), .an_engine_restart(eng_rst), .an_enable_out(ane_o),
		.an_engine_done(done), .an_result_speed_100(rs), .an_result_full_duplex(rf),
		.an_partner_ack(ack), .delay(dly), .result(res)
	);

	// expected register values
	function automatic pbc_word_t ctrl_exp(logic s, logic a, logic f, logic [1:0] r);
		return a ? {2'h0, r[1], 4'h8, r[0], 8'h00} : {2'h0, s, 4'h0, f, 8'h00};
	endfunction
	function automatic pbc_word_t adv_exp(pbc_word_t w, logic k);
		return (w & 16'h21E0) | 16'h0001 | {5'h00, cfg[0], 10'h000} | {1'b0, k, 14'h0000};
	endfunction
	function automatic pbc_word_t stat_exp(logic anc, logic flt);
		return 16'h7809 | {10'h000, anc, flt, 4'h0};
	endfunction

	task automatic chk(input pbc_word_t got, input pbc_word_t exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input pbc_word_t v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input pbc_word_t exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(reg_rdata, exp);
	endtask
	task automatic wait_done();
		for (int n = 0; n < 200 && done !== 1'b1; n++) begin
			@(negedge sys_clk);
		end
		chk({15'h0000, done}, 16'h0001);
		@(posedge sys_clk);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#(5000 * 50);
		err_count++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'h2C23));
		repeat (3) @(posedge sys_clk);
		cfg <= 4'($urandom);
		reset <= 1'b0;
		repeat (8) @(posedge sys_clk);
		// power-up values
		rd(`PBC_OFS_CTRL, ctrl_exp(cfg[3], cfg[2], cfg[1], 2'h0));
		rd(`PBC_OFS_STAT, stat_exp(1'b0, 1'b0));
		rd(`PBC_OFS_ADV, adv_exp(16'h01E0, 1'b0));
		// every speed and duplex mode, restart dropped while disabled
		for (int i = 0; i < 4; i++) begin
			d = 16'($urandom);
			wr(`PBC_OFS_CTRL, {2'h0, i[1], 4'h1, i[0], 8'h00} | (d & 16'h4CFF));
			rd(`PBC_OFS_CTRL, ctrl_exp(i[1], 1'b0, i[0], 2'h0));
			chk({13'h0000, ane_o, spd_o, fdx_o}, {13'h0000, 1'b0, i[1], i[0]});
			wr(`PBC_OFS_ADV, d);
			rd(`PBC_OFS_ADV, adv_exp(d, 1'b0));
			chk(adv_o, adv_exp(d, 1'b0));
		end
		// read-only and unmapped places
		wr(`PBC_OFS_STAT, 16'hFFFF);
		wr(16'h0146, 16'hFFFF);
		rd(`PBC_OFS_STAT, stat_exp(1'b0, 1'b0));
		rd(16'h0146, 16'h0000);
		// negotiation with interrupt
		wr(`PBC_OFS_IRQ_MASK, 16'h0007);
		for (int i = 0; i < 2; i++) begin
			res <= 2'($urandom);
			dly <= 6'($urandom_range(0, 40));
			wr(`PBC_OFS_CTRL, 16'h1200 | (d & 16'h2100));
			wait_done();
			rd(`PBC_OFS_STAT, stat_exp(1'b1, 1'b0));
			rd(`PBC_OFS_CTRL, ctrl_exp(1'b0, 1'b1, 1'b0, res));
			rd(`PBC_OFS_ADV, adv_exp(d, 1'b1));
			chk({12'h000, ane_o, spd_o, fdx_o, irq}, {12'h000, 1'b1, res, 1'b1});
			rd(`PBC_OFS_IRQ_STAT, 16'h0005);
			wr(`PBC_OFS_IRQ_STAT, 16'h0007);
			rd(`PBC_OFS_IRQ_STAT, 16'h0000);
			chk({15'h0000, irq}, 16'h0000);
		end
		// remote fault, masked then unmasked
		wr(`PBC_OFS_IRQ_MASK, 16'h0001);
		@(posedge sys_clk);
		rflt <= 1'b1;
		@(posedge sys_clk);
		rflt <= 1'b0;
		rd(`PBC_OFS_STAT, stat_exp(1'b1, 1'b1));
		rd(`PBC_OFS_STAT, stat_exp(1'b1, 1'b0));
		chk({15'h0000, irq}, 16'h0000);
		rd(`PBC_OFS_IRQ_STAT, 16'h0002);
		wr(`PBC_OFS_IRQ_MASK, 16'h0002);
		repeat (2) @(negedge sys_clk);
		chk({15'h0000, irq}, 16'h0001);
		wr(`PBC_OFS_IRQ_STAT, 16'h0002);
		repeat (2) @(negedge sys_clk);
		chk({15'h0000, irq}, 16'h0000);
		// software reset with other bits set
		dly <= 6'h28;
		wr(`PBC_OFS_CTRL, 16'hBFFF);
		repeat (8) @(posedge sys_clk);
		rd(`PBC_OFS_CTRL, ctrl_exp(cfg[3], cfg[2], cfg[1], 2'h0));
		rd(`PBC_OFS_ADV, adv_exp(16'h01E0, 1'b0));
		rd(`PBC_OFS_STAT, stat_exp(1'b0, 1'b0));
		wrap_up();
	end
endmodule
